// ---- design/tws_params.svh ----
// Timing and field constants of the two-wire master sequencer
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ****************************************
// Bus clock divider
// ****************************************
`define TWS_RELOAD_ZERO_CODE 8'h00
`define TWS_RELOAD_ZERO      9'h100
`define TWS_HALF_LSBS        2'b00
`define TWS_HALF_ADD         11'h001
`define TWS_TMR_STEP         11'h001
`define TWS_TMR_ZERO         11'h000

// ****************************************
// Byte framing
// ****************************************
`define TWS_BIT_FIRST        4'h0
`define TWS_BIT_STEP         4'h1
`define TWS_LAST_DATA_BIT    4'h7
`define TWS_ACK_BIT          4'h8
`define TWS_DIR_BIT          0
`define TWS_ADDR_MSB         7
`define TWS_ADDR_LSB         1
`define TWS_BYTE_ZERO        8'h00

// ****************************************
// Condition sequencing phases
// ****************************************
`define TWS_PH_FIRST         2'h0
`define TWS_PH_SCL_UP        2'h1
`define TWS_PH_START         2'h2
`define TWS_PH_LAST          2'h3
`define TWS_PH_STOP_END      2'h2
`define TWS_PH_STEP          2'h1

`endif

// ---- design/tws_pkg.sv ----
// Types shared by the two-wire master sequencer
package tws_pkg;

	// ****************************************
	// Firmware control pulses
	// ****************************************
	typedef struct packed {
		logic start_set;
		logic start_clr;
		logic stop_set;
		logic start_sent_clr;
		logic byte_sent_clr;
		logic byte_received_clr;
		logic status_read;
	} tws_ctl_t;

	// ****************************************
	// Status seen by firmware
	// ****************************************
	typedef struct packed {
		logic start_request;
		logic stop_request;
		logic start_sent_flag;
		logic byte_sent_flag;
		logic byte_received_flag;
		logic arbitration_lost_flag;
		logic own_address_match;
		logic ack_status;
		logic transmit_direction;
		logic bus_busy;
	} tws_status_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} tws_rx_t;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_START  = 7'h02,
		ST_WAIT   = 7'h04,
		ST_LO     = 7'h08,
		ST_HI     = 7'h10,
		ST_STOP   = 7'h20,
		ST_RSTART = 7'h40
	} tws_state_t;

endpackage

// ---- design/tws_master.sv ----
// Two-wire master sequencer: start, stop, bytes, acknowledge, arbitration
// What this block does
// - Any reset leaves the port idle in slave receive.
// - On start_request wait for a free bus, send start, flag it, direction 1.
// - First byte is address plus direction; it shifts out once written.
// - Set byte_sent_flag after address and acknowledge have passed.
// - Clearing byte_sent_flag in transmit loads the transmit buffer.
// - start_request after byte_sent_flag gives an immediate repeated start.
// - stop_request ends transmit and switches to receive direction.
// - After the stop, stop_request self-clears and direction stays 0.
// - A driven 1 read back as 0 loses arbitration at once.
// - After loss, clock the byte out, flag loss, buffer the winner's byte.
// - Loss in the address byte matching own address sets own_address_match.
// - Read address acknowledged: flag, record acknowledge, direction to 0.
// - Master receive waits until byte_sent_flag is cleared.
// - Acknowledge received bytes unless nack_select asks for a negative one.
// - Buffer each received byte and flag it as the acknowledge is driven.
// - Next received byte starts once the flag is clear.
// - After the last byte a stop ends the read, direction stays 0.
// - In receive, a pulled-low negative acknowledge loses arbitration; clocks stop.
// - The master makes every clock, start and stop.
// - Bus clock is held low while byte_sent_flag or byte_received_flag stays set, unless a stop or repeated start is requested.
// - Bit period is core clock times eight reload plus two; zero means 256.
// - Reading the first status register clears the loss and match flags.
`timescale 1ns/100ps
`include "tws_params.svh"

module tws_master import tws_pkg::*; (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Firmware control
	input  wire tws_ctl_t    ctl,
	input  wire logic        nack_select,
	input  wire logic [6:0]  own_address_register,
	input  wire logic [7:0]  clock_reload_value,
	input  wire logic        tx_write,
	input  wire logic [7:0]  tx_data,
	output tws_status_t      status,
	// Receive buffer
	output tws_rx_t          rx_out,
	input  wire logic        rx_ready,
	// Bus pins
	input  wire logic        serial_clock_line_in,
	output logic             serial_clock_line_out,
	output logic             serial_clock_line_oe,
	input  wire logic        serial_data_line_in,
	output logic             serial_data_line_out,
	output logic             serial_data_line_oe
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0]  sy1_q;
	logic [1:0]  sy2_q;
	logic [1:0]  sy3_q;
	logic [1:0]  filt_q;
	logic [1:0]  prev_q;

	// Bit 1 is the clock line, bit 0 the data line
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sy1_q  <= 2'h3;
			sy2_q  <= 2'h3;
			sy3_q  <= 2'h3;
			filt_q <= 2'h3;
			prev_q <= 2'h3;
		end else begin
			sy1_q  <= {serial_clock_line_in, serial_data_line_in};
			sy2_q  <= sy1_q;
			sy3_q  <= sy2_q;
			prev_q <= filt_q;
			if (sy2_q == sy3_q) begin
				filt_q <= sy3_q;
			end
		end
	end

	wire scl_f     = filt_q[1];
	wire sda_f     = filt_q[0];
	wire start_det = scl_f && prev_q[1] && prev_q[0] && !sda_f;
	wire stop_det  = scl_f && prev_q[1] && !prev_q[0] && sda_f;

	// ****************************************
	// State and registers
	// ****************************************
	tws_state_t  state_q;
	tws_state_t  state_d;
	logic [1:0]  ph_q;
	logic [1:0]  ph_d;
	logic [10:0] tmr_q;
	logic [3:0]  bit_q;
	logic [7:0]  shift_q;
	logic [7:0]  txbuf_q;
	logic        tx_pend_q;
	logic        tx_go_q;
	logic        addr_ph_q;
	logic        cur_addr_q;
	logic        rx_mode_q;
	logic        lost_q;
	logic        nak_q;
	logic        start_req_q;
	logic        stop_req_q;
	logic        start_sent_q;
	logic        byte_sent_q;
	logic        byte_rcvd_q;
	logic        arb_lost_q;
	logic        own_match_q;
	logic        ack_q;
	logic        xdir_q;
	logic        busy_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        pin_out_q;
	tws_rx_t     out_q;
	tws_rx_t     sk_q;

	// ****************************************
	// Bus clock timing
	// ****************************************
	wire [8:0]  reload_eff = (clock_reload_value == `TWS_RELOAD_ZERO_CODE) ?
	                         `TWS_RELOAD_ZERO : {1'b0, clock_reload_value};
	wire [10:0] half_w     = {reload_eff, `TWS_HALF_LSBS} + `TWS_HALF_ADD;
	wire [10:0] tmr_inc    = tmr_q + `TWS_TMR_STEP;
	wire        tmr_done   = (tmr_inc == half_w);
	// A released clock line that is still low is a stretching slave: wait
	wire        tmr_run    = scl_oe_q || scl_f;

	// ****************************************
	// Events and decisions
	// ****************************************
	wire is_ack    = (bit_q == `TWS_ACK_BIT);
	wire is_last   = (bit_q == `TWS_LAST_DATA_BIT);
	wire in_wait   = (state_q == ST_WAIT);
	wire hi_end    = (state_q == ST_HI) && tmr_done;
	wire line_low  = (state_q == ST_HI) && scl_f && !sda_oe_q && !sda_f;
	wire ev_arb    = line_low && !rx_mode_q && !lost_q && !is_ack;
	wire ev_nlost  = line_low && rx_mode_q && is_ack;
	wire ev_txbyte = hi_end && is_ack && !rx_mode_q && !lost_q;
	wire ev_rxbyte = hi_end && is_last && rx_mode_q;
	wire ev_lost   = hi_end && is_last && lost_q;
	wire seq_done  = tmr_done && (ph_q == `TWS_PH_LAST) &&
	                 ((state_q == ST_START) || (state_q == ST_RSTART));
	wire stop_done = tmr_done && (ph_q == `TWS_PH_STOP_END) && (state_q == ST_STOP);
	wire [7:0] shift_next = {shift_q[6:0], sda_f};
	wire addr_dir  = cur_addr_q && shift_q[`TWS_DIR_BIT];
	wire own_hit   = (shift_next[`TWS_ADDR_MSB:`TWS_ADDR_LSB] == own_address_register);

	wire go_start  = start_req_q && !stop_req_q && !busy_q;
	// A repeated start needs a finished byte since the last start, or it would repeat at once
	wire go_rs     = start_req_q && byte_sent_q && !addr_ph_q;
	wire go_addr   = addr_ph_q && tx_pend_q && !byte_sent_q;
	wire go_data   = xdir_q && tx_go_q;
	wire go_recv   = rx_mode_q && !byte_sent_q && !byte_rcvd_q && !sk_q.valid;
	wire go_byte   = go_addr || go_data || go_recv;
	wire load_tx   = in_wait && !stop_req_q && !go_rs && (go_addr || go_data);
	wire rx_push   = (ev_rxbyte || ev_lost) && !sk_q.valid;

	// ****************************************
	// Line drive
	// ****************************************
	wire is_seq    = (state_q == ST_START) || (state_q == ST_RSTART);
	// Acknowledge choice is frozen as the byte completes, so a late nack_select hits the next byte
	wire drive_w   = !lost_q && (rx_mode_q ? (is_ack && !nak_q) :
	                 (!is_ack && !shift_q[7]));
	wire scl_oe_d  = in_wait || (state_q == ST_LO) ||
	                 (is_seq && ((ph_q == `TWS_PH_FIRST) || (ph_q == `TWS_PH_LAST))) ||
	                 ((state_q == ST_STOP) && (ph_q == `TWS_PH_FIRST));
	wire sda_oe_d  = (state_q == ST_LO) ? drive_w :
	                 is_seq ? (ph_q >= `TWS_PH_START) :
	                 (state_q == ST_STOP) ? (ph_q <= `TWS_PH_SCL_UP) :
	                 (in_wait || (state_q == ST_HI)) ? sda_oe_q : 1'b0;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		ph_d    = ph_q;
		case (state_q)
			ST_IDLE: begin
				if (go_start) begin
					state_d = ST_START;
					ph_d    = `TWS_PH_START;
				end
			end
			ST_START, ST_RSTART: begin
				if (tmr_done) begin
					if (ph_q == `TWS_PH_LAST) begin
						state_d = ST_WAIT;
					end else begin
						ph_d = ph_q + `TWS_PH_STEP;
					end
				end
			end
			ST_STOP: begin
				if (tmr_done) begin
					if (ph_q == `TWS_PH_STOP_END) begin
						state_d = ST_IDLE;
					end else begin
						ph_d = ph_q + `TWS_PH_STEP;
					end
				end
			end
			ST_WAIT: begin
				// Stop before start when both are asked for
				if (stop_req_q) begin
					state_d = ST_STOP;
					ph_d    = `TWS_PH_FIRST;
				end else if (go_rs) begin
					state_d = ST_RSTART;
					ph_d    = `TWS_PH_FIRST;
				end else if (go_byte) begin
					state_d = ST_LO;
				end
			end
			ST_LO: begin
				if (tmr_done) begin
					state_d = ST_HI;
				end
			end
			ST_HI: begin
				if (ev_nlost || ev_lost) begin
					state_d = ST_IDLE;
				end else if (tmr_done) begin
					state_d = is_ack ? ST_WAIT : ST_LO;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			ph_q    <= `TWS_PH_FIRST;
			tmr_q   <= `TWS_TMR_ZERO;
		end else begin
			state_q <= state_d;
			ph_q    <= ph_d;
			if ((state_d != state_q) || (ph_d != ph_q) || !tmr_run) begin
				tmr_q <= (state_d != state_q) || (ph_d != ph_q) ? `TWS_TMR_ZERO : tmr_q;
			end else begin
				tmr_q <= tmr_inc;
			end
		end
	end

	// ****************************************
	// Byte path
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bit_q   <= `TWS_BIT_FIRST;
			shift_q <= `TWS_BYTE_ZERO;
			txbuf_q <= `TWS_BYTE_ZERO;
		end else begin
			bit_q <= in_wait ? `TWS_BIT_FIRST : hi_end ? bit_q + `TWS_BIT_STEP : bit_q;
			if (load_tx) begin
				shift_q <= txbuf_q;
			end else if (hi_end && !is_ack) begin
				shift_q <= shift_next;
			end
			if (tx_write) begin
				txbuf_q <= tx_data;
			end
		end
	end

	// ****************************************
	// Transfer control
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tx_pend_q  <= 1'b0;
			tx_go_q    <= 1'b0;
			addr_ph_q  <= 1'b0;
			cur_addr_q <= 1'b0;
			rx_mode_q  <= 1'b0;
			lost_q     <= 1'b0;
			xdir_q     <= 1'b0;
			busy_q     <= 1'b0;
			ack_q      <= 1'b0;
			nak_q      <= 1'b0;
		end else begin
			tx_pend_q  <= tx_write || (tx_pend_q && !load_tx);
			tx_go_q    <= (ctl.byte_sent_clr && byte_sent_q && xdir_q) ||
			              (tx_go_q && !load_tx && !stop_req_q);
			addr_ph_q  <= seq_done || (addr_ph_q && !(load_tx && go_addr));
			cur_addr_q <= load_tx ? go_addr : cur_addr_q;
			rx_mode_q  <= (ev_txbyte && addr_dir) ||
			              (rx_mode_q && !seq_done && (state_d != ST_IDLE));
			lost_q     <= ev_arb || (lost_q && !ev_lost);
			busy_q     <= start_det || (busy_q && !stop_det);
			if (ev_txbyte) begin
				ack_q <= !sda_f;
			end
			if (ev_rxbyte) begin
				nak_q <= nack_select;
			end
			if (seq_done) begin
				xdir_q <= 1'b1;
			end else if (ctl.stop_set || stop_done || ev_arb || ev_nlost ||
			             (ev_txbyte && addr_dir)) begin
				xdir_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status flags: a set beats a clear
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			start_req_q  <= 1'b0;
			stop_req_q   <= 1'b0;
			start_sent_q <= 1'b0;
			byte_sent_q  <= 1'b0;
			byte_rcvd_q  <= 1'b0;
			arb_lost_q   <= 1'b0;
			own_match_q  <= 1'b0;
		end else begin
			start_req_q  <= ctl.start_set || (start_req_q && !ctl.start_clr);
			stop_req_q   <= ctl.stop_set || (stop_req_q && !stop_done);
			start_sent_q <= seq_done || (start_sent_q && !ctl.start_sent_clr);
			byte_sent_q  <= ev_txbyte || (byte_sent_q && !ctl.byte_sent_clr);
			byte_rcvd_q  <= ev_rxbyte || (byte_rcvd_q && !ctl.byte_received_clr);
			arb_lost_q   <= ev_lost || ev_nlost ||
			                (arb_lost_q && !ctl.status_read);
			own_match_q  <= (ev_lost && cur_addr_q && own_hit) ||
			                (own_match_q && !ctl.status_read);
		end
	end

	// ****************************************
	// Two-entry receive buffer
	// ****************************************
	// A byte won by another master cannot be paused, so it is dropped if full
	wire rx_pop = rx_ready && out_q.valid;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			out_q <= '0;
			sk_q  <= '0;
		end else if (!out_q.valid || rx_pop) begin
			out_q <= sk_q.valid ? sk_q : '{valid: rx_push, data: shift_next};
			sk_q  <= sk_q.valid ? '{valid: rx_push, data: shift_next} : '0;
		end else if (rx_push) begin
			sk_q  <= '{valid: 1'b1, data: shift_next};
		end
	end

	// ****************************************
	// Pin registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			pin_out_q <= 1'b0;
		end else begin
			scl_oe_q  <= scl_oe_d;
			sda_oe_q  <= sda_oe_d;
			pin_out_q <= 1'b0;
		end
	end

	assign serial_clock_line_oe  = scl_oe_q;
	assign serial_data_line_oe   = sda_oe_q;
	assign serial_clock_line_out = pin_out_q;
	assign serial_data_line_out  = pin_out_q;
	assign rx_out                = out_q;
	assign status = '{start_request: start_req_q, stop_request: stop_req_q,
	                  start_sent_flag: start_sent_q, byte_sent_flag: byte_sent_q,
	                  byte_received_flag: byte_rcvd_q, arbitration_lost_flag: arb_lost_q,
	                  own_address_match: own_match_q, ack_status: ack_q,
	                  transmit_direction: xdir_q, bus_busy: busy_q};

	// ****************************************
	// Checks
	// ****************************************
	a_reset_idle: assert property (@(posedge clk_sys)
		!reset_n |=> (state_q == ST_IDLE) && !xdir_q)
		else $error("reset did not leave port idle");
	a_start_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_done |=> start_sent_q && xdir_q && (state_q == ST_WAIT))
		else $error("start sent without flag or direction");
	a_hold_clock: assert property (@(posedge clk_sys) disable iff (!reset_n)
		in_wait && byte_sent_q && $past(in_wait) |-> serial_clock_line_oe)
		else $error("clock released while byte flag set");
	a_ack_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ev_txbyte |=> byte_sent_q && (ack_q == $past(!sda_f)))
		else $error("byte flag or acknowledge not recorded");
	a_stop_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stop_done && !ctl.stop_set |=> !stop_req_q && !xdir_q ##1 (state_q != ST_STOP))
		else $error("stop request not cleared after stop");
	a_lost_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
		lost_q && (state_q == ST_LO) && $past(state_q == ST_LO) |=> !serial_data_line_oe)
		else $error("data still driven after arbitration loss");
	a_nack_lost: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ev_nlost |=> arb_lost_q && (state_q == ST_IDLE) ##1 !serial_clock_line_oe)
		else $error("clocks continue after receive arbitration loss");
	a_rx_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ev_rxbyte |=> byte_rcvd_q && (state_q == ST_LO))
		else $error("received byte not flagged at acknowledge");
	a_read_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctl.status_read && !ev_lost && !ev_nlost |=> !arb_lost_q && !own_match_q)
		else $error("status read did not clear loss flags");

endmodule

// ---- bench/tws_slave_model.sv ----
// Behavioural two-wire slave on the far side of the sequencer's bus
`timescale 1ns/100ps

module tws_slave_model #(
	parameter logic [6:0] SLV_ADDR = 7'h3c
) (
	// Clock and bus levels
	input  wire logic        clk_sys,
	input  wire logic        scl,
	input  wire logic        sda,
	// Bytes returned on a read
	input  wire logic [15:0] rd_data,
	// Line pull and observations
	output logic             sda_oe = 1'b0,
	output logic [6:0]       got_addr = 7'h00,
	output logic [7:0]       got_byte = 8'h00,
	output logic [3:0]       start_count = 4'h0,
	output logic             master_nack = 1'b0
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic       act = 1'b0;
	logic       first = 1'b0;
	logic       sel = 1'b0;
	logic       rd = 1'b0;
	logic       bidx = 1'b0;
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	wire  [7:0] cur = bidx ? rd_data[7:0] : rd_data[15:8];

	// Line changes only after a clock fall, so data never moves while the clock is high
	always @(posedge clk_sys) begin
		scl_q <= scl;
		sda_q <= sda;
		if (scl && scl_q && sda_q && !sda) begin
			act <= 1'b1;
			first <= 1'b1;
			rd <= 1'b0;
			cnt <= 4'h0;
			sda_oe <= 1'b0;
			start_count <= start_count + 4'h1;
		end else if (scl && scl_q && !sda_q && sda) begin
			act <= 1'b0;
			sda_oe <= 1'b0;
		end else if (act && scl && !scl_q) begin
			if (cnt < 4'h8)
				sh <= {sh[6:0], sda};
			if (cnt == 4'h8 && rd)
				master_nack <= sda;
			cnt <= cnt + 4'h1;
		end else if (act && !scl && scl_q) begin
			if (cnt == 4'h8) begin
				if (rd) begin
					sda_oe <= 1'b0;
				end else if (first) begin
					sel <= (sh[7:1] == SLV_ADDR);
					sda_oe <= (sh[7:1] == SLV_ADDR);
					got_addr <= sh[7:1];
				end else begin
					sda_oe <= sel;
					got_byte <= sh;
				end
			end else if (cnt == 4'h9) begin
				cnt <= 4'h0;
				first <= 1'b0;
				if (first && sel && sh[0]) begin
					rd <= 1'b1;
					bidx <= 1'b0;
					sda_oe <= !rd_data[15];
				end else if (rd && !master_nack) begin
					bidx <= 1'b1;
					sda_oe <= !rd_data[7];
				end else begin
					rd <= 1'b0;
					sda_oe <= 1'b0;
				end
			end else if (rd) begin
				sda_oe <= !cur[3'h7 - cnt[2:0]];
			end
		end
	end
endmodule

// ---- bench/tb_tws_master.sv ----
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps

module tb_tws_master import tws_pkg::*;;
	localparam tws_ctl_t C_STA = 7'h40;
	localparam tws_ctl_t C_SCL = 7'h20;
	localparam tws_ctl_t C_STO = 7'h10;
	localparam tws_ctl_t C_SSC = 7'h08;
	localparam tws_ctl_t C_BSC = 7'h04;
	localparam tws_ctl_t C_BRC = 7'h02;
	localparam tws_ctl_t C_RD  = 7'h01;

	typedef struct {
		logic [7:0] rl;
		logic [6:0] ad;
		logic [7:0] d;
		logic       ak;
	} tws_row_t;

	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	tws_ctl_t    ctl = '0;
	logic        nack_select = 1'b0;
	logic [6:0]  own_address_register = 7'h00;
	logic [7:0]  clock_reload_value = 8'h02;
	logic        tx_write = 1'b0;
	logic [7:0]  tx_data = 8'h00;
	logic        rx_ready = 1'b0;
	logic        other_oe = 1'b0;
	tws_status_t status;
	tws_rx_t     rx_out;
	logic        scl_oe;
	logic        sda_oe;
	logic        slv_oe;
	logic [6:0]  got_addr;
	logic [7:0]  got_byte;
	logic [3:0]  start_count;
	logic [3:0]  starts;
	logic        master_nack;
	logic [15:0] n_lo;
	int          fail_count = 0;
	int          total_checks = 0;
	tws_row_t    rows[4] = '{
		'{8'h02, 7'h3c, 8'ha5, 1'b1},
		'{8'h03, 7'h3c, 8'h5a, 1'b1},
		'{8'h04, 7'h3c, 8'hff, 1'b1},
		'{8'h02, 7'h11, 8'h00, 1'b0}
	};
	// Open-drain wires with pull-ups
	wire         scl_lvl = !scl_oe;
	wire         sda_lvl = !(sda_oe || slv_oe || other_oe);

	always #5 clk_sys = !clk_sys;

	tws_master dut_u (
		.clk_sys              (clk_sys),
		.reset_n              (reset_n),
		.ctl                  (ctl),
		.nack_select          (nack_select),
		.own_address_register (own_address_register),
		.clock_reload_value   (clock_reload_value),
		.tx_write             (tx_write),
		.tx_data              (tx_data),
		.status               (status),
		.rx_out               (rx_out),
		.rx_ready             (rx_ready),
		.serial_clock_line_in (scl_lvl),
		.serial_clock_line_out(),
		.serial_clock_line_oe (scl_oe),
		.serial_data_line_in  (sda_lvl),
		.serial_data_line_out (),
		.serial_data_line_oe  (sda_oe)
	);

	tws_slave_model slv_u (
		.clk_sys    (clk_sys),
		.scl        (scl_lvl),
		.sda        (sda_lvl),
		.rd_data    (16'hc35e),
		.sda_oe     (slv_oe),
		.got_addr   (got_addr),
		.got_byte   (got_byte),
		.start_count(start_count),
		.master_nack(master_nack)
	);

	// ****************************************
	// Bench tasks
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Bounded wait on one status bit, sampled away from the active edge
	task automatic wt(input int idx, input logic v);
		int n;
		n = 0;
		@(negedge clk_sys);
		while (status[idx] !== v && n < 40000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 40000) begin
			fail_count++;
			$display("[FAIL] %0t status wait ran out", $time);
			end_of_test();
		end
	endtask

	// Width of one low clock half inside a byte, counted on falling clock edges
	task automatic lo_len(output logic [15:0] n);
		int k;
		n = 16'h0000;
		k = 0;
		while (scl_oe !== 1'b0 && k < 4000) begin
			@(negedge clk_sys);
			k++;
		end
		while (scl_oe !== 1'b1 && k < 4000) begin
			@(negedge clk_sys);
			k++;
		end
		while (scl_oe === 1'b1 && k < 4000) begin
			@(negedge clk_sys);
			k++;
			n = n + 16'h0001;
		end
		if (k >= 4000) begin
			fail_count++;
			$display("[FAIL] %0t clock width wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic ctl_p(input tws_ctl_t c);
		@(posedge clk_sys);
		ctl <= c;
		@(posedge clk_sys);
		ctl <= '0;
	endtask

	task automatic txw(input logic [7:0] d);
		@(posedge clk_sys);
		tx_write <= 1'b1;
		tx_data <= d;
		@(posedge clk_sys);
		tx_write <= 1'b0;
	endtask

	task automatic do_start(input logic [7:0] ab);
		ctl_p(C_STA);
		wt(7, 1'b1);
		check(status[1], 1'b1, "direction after start");
		txw(ab);
		ctl_p(C_SSC | C_SCL);
		wt(6, 1'b1);
	endtask

	task automatic do_stop(input tws_ctl_t extra);
		ctl_p(C_STO | extra);
		@(negedge clk_sys);
		check(status[1], 1'b0, "direction after stop request");
		ctl_p(C_BSC);
		wt(8, 1'b0);
		check(status[1], 1'b0, "direction after stop");
		wt(0, 1'b0);
	endtask

	task automatic pop(input logic [7:0] exp);
		check(rx_out.valid, 1'b1, "receive buffer valid");
		check(rx_out.data, exp, "receive buffer data");
		@(posedge clk_sys);
		rx_ready <= 1'b1;
		@(posedge clk_sys);
		rx_ready <= 1'b0;
		@(negedge clk_sys);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(negedge clk_sys);
		check(status, '0, "status after reset");
		check({scl_oe, sda_oe, rx_out.valid}, 3'h0, "pins after reset");
		repeat (6) @(posedge clk_sys);
		foreach (rows[i]) begin
			@(posedge clk_sys);
			clock_reload_value <= rows[i].rl;
			do_start({rows[i].ad, 1'b0});
			check(status[2], rows[i].ak, "address acknowledge");
			repeat (60) @(negedge clk_sys);
			check(scl_oe, 1'b1, "clock held while flag set");
			if (rows[i].ak) begin
				txw(rows[i].d);
				ctl_p(C_BSC);
				lo_len(n_lo);
				check(n_lo, (16'h0008 * rows[i].rl + 16'h0002) >> 1, "low clock half");
				wt(6, 1'b1);
				check(got_byte, rows[i].d, "byte seen by slave");
			end
			do_stop('0);
		end
		// Repeated start turning a write into a two-byte read
		starts = start_count;
		do_start({7'h3c, 1'b0});
		txw(8'h81);
		ctl_p(C_BSC);
		wt(6, 1'b1);
		ctl_p(C_STA);
		wt(7, 1'b1);
		check(start_count, starts + 4'h2, "repeated start on bus");
		ctl_p(C_SSC);
		txw({7'h3c, 1'b1});
		ctl_p(C_BSC);
		ctl_p(C_SCL);
		wt(6, 1'b1);
		check({status[2], status[1]}, 2'b10, "read address acknowledged");
		check(start_count, starts + 4'h2, "no start after repeated start address");
		ctl_p(C_BSC);
		wt(5, 1'b1);
		check(rx_out.data, 8'hc3, "first read byte");
		@(posedge clk_sys);
		nack_select <= 1'b1;
		ctl_p(C_BRC);
		wt(5, 1'b1);
		check(rx_out.data, 8'hc3, "head kept while second shifts");
		@(posedge clk_sys);
		nack_select <= 1'b0;
		do_stop(C_BRC);
		check(master_nack, 1'b1, "last byte not acknowledged");
		pop(8'hc3);
		pop(8'h5e);
		check(rx_out.valid, 1'b0, "receive buffer empty");
		// Another master wins the address byte
		ctl_p(C_STA);
		wt(7, 1'b1);
		@(posedge clk_sys);
		other_oe <= 1'b1;
		txw(8'ha4);
		ctl_p(C_SSC | C_SCL);
		wt(4, 1'b1);
		check(status[1], 1'b0, "slave receive after loss");
		check(status[3], 1'b1, "own address match");
		@(posedge clk_sys);
		other_oe <= 1'b0;
		ctl_p(C_RD);
		@(negedge clk_sys);
		check({status[4], status[3]}, 2'b00, "status read clears flags");
		pop(8'h00);
		// Another master pulls the line low during our negative acknowledge
		do_start({7'h3c, 1'b1});
		@(posedge clk_sys);
		nack_select <= 1'b1;
		ctl_p(C_BSC);
		wt(5, 1'b1);
		@(posedge clk_sys);
		other_oe <= 1'b1;
		wt(4, 1'b1);
		@(negedge clk_sys);
		check({status[1], scl_oe}, 2'b00, "clocks stop after receive loss");
		@(posedge clk_sys);
		other_oe <= 1'b0;
		nack_select <= 1'b0;
		ctl_p(C_RD | C_BRC);
		pop(8'hc3);
		end_of_test();
	end
endmodule
